// *** logic/scr_cfg.svh ***
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
// ****************************************************************
// Clock, timing and register constants
// ****************************************************************
`define SCR_CLK_HZ 100000000
`define SCR_HOST_DIV13 13
`define SCR_APD_T0_S 8'd4
`define SCR_APD_T1_S 8'd32
`define SCR_APD_T2_S 8'd64
`define SCR_APD_T3_MIN 8'd4
`define SCR_APD_T3_S (`SCR_APD_T3_MIN * 8'd60)
// Configuration register indices
`define SCR_IDX_PROTECT 8'h08
`define SCR_IDX_MODE 8'h09
`define SCR_IDX_PORTABLE 8'h0a
`define SCR_IDX_FLOPPY 8'h0b
`define SCR_IDX_UART 8'h0c
`define SCR_IDX_IR 8'h0d
`define SCR_IDX_LOCK_LAST 8'h29
// Reset values
`define SCR_RST_PROTECT 8'h00
`define SCR_RST_MODE 3'h0
`define SCR_RST_PORTABLE 8'h1f
`define SCR_RST_FLOPPY 5'h0c
`define SCR_RST_UART 8'h28
`define SCR_RST_IR 8'ha3
// Host I/O addresses and key values
`define SCR_KEY_PORT_LO 16'h0250
`define SCR_KEY_PORT_HI 16'h03f0
`define SCR_TAPE_PORT 16'h03f3
`define SCR_KEY_00 8'h88
`define SCR_KEY_01 8'h89
`define SCR_KEY_10 8'h86
`define SCR_KEY_11 8'h87
`define SCR_EXIT_KEY 8'haa
// Field positions
`define SCR_B_WR_DISABLE 5
`define SCR_B_SW_PROTECT 4
`define SCR_B_LOCK 6
`define SCR_B_3MODE 5
`define SCR_B_IFCHG 4
`define SCR_B_DRVTYPE 3
`define SCR_B_RECSEL 2
`define SCR_B_FDPOL 1
`define SCR_B_DRV2 0
`define SCR_B_KEYLO 5
`define SCR_B_IRSEL 3
`define SCR_B_INFRARED_HALF_DUPLEX 3
`endif

// *** logic/scr_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"
// Notes on behaviour
// R1: Two-bit field picks power-down countdown
// R2: Write-disable forces write gate, data inactive
// R3: Software protect reports drive always protected
// R4: Media id and boot drive bits stored
// R5: Access through index then data port
// R6: Lock bit blocks register reads and writes
// R7: Three-mode bit enables tape register access
// R8: Tape bits 5:4 steer reduced-write-current
// R9: Fixed read-only chip id low nibble
// R10: Polarity bits for portable pins, dock
// R11: Mask bits gate extension enable per mode
// R12: Floppy register bits 7:5 read zero
// R13: Mode reloads at reset or change-enable
// R14: 00 compat, 01 system2, else AT
// R15: Drive type sets reduced-write-current polarity
// R16: Polarity bit inverts floppy drive signals
// R17: System2 mode reports second drive installed
// R18: UART clock select: divide-13 or direct
// R19: Unlock key chosen by two select bits
// R20: IR select bit routes UART B
// R21: Receive and transmit invert bits
// R22: Pin selects route IR, 00/11 off
// R23: Duplex bit picks full or half
// R24: IR mode 00x disables, others route
// R25: Locked: writes ignored, reads zero
// R26: Power-down count reloads on floppy activity
module scr_config_regs
  import scr_pkg::*;
#(
  parameter logic [3:0] CHIP_ID = 4'h5, // Arbitrary identification value
  parameter int SEC_CYCLES = `SCR_CLK_HZ
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_valid,
  input wire logic i_key_select_hi_strap,
  input wire logic i_floppy_activity,
  output logic o_powerdown_request,
  input wire logic i_fdc_write_gate_n,
  input wire logic i_fdc_write_data_n,
  output logic o_drive_write_gate_n,
  output logic o_drive_write_data_n,
  input wire logic i_drive_write_protect_in_n,
  output logic o_write_protected,
  output logic [1:0] o_media_id,
  output logic [1:0] o_boot_drive,
  input wire logic i_fdc_high_rate,
  output logic o_reduced_write_current_n,
  output logic o_parallel_mode_select_hi,
  output logic o_three_mode_enable,
  input wire logic i_floppy_enable_req,
  output logic o_portable_floppy_enable_out,
  input wire logic [3:0] i_parallel_mode,
  output logic o_portable_ext_enable_out,
  input wire logic i_dock_detect_in,
  output logic o_docked,
  output logic [1:0] o_host_if_mode,
  output logic o_second_drive_installed,
  output logic o_uart_a_baud_tick,
  output logic o_uart_b_baud_tick,
  input wire logic i_uart_b_sout,
  input wire logic i_uart_b_serial_in,
  input wire logic i_infrared_receive1,
  input wire logic i_infrared_receive2,
  output logic o_uart_b_sin,
  output logic o_uart_b_serial_out,
  output logic o_infrared_transmit1,
  output logic o_infrared_transmit1_oe,
  output logic o_infrared_transmit2,
  output logic o_infrared_transmit2_oe,
  output logic o_infrared_half_duplex
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] cr_protect;
  logic [2:0] cr_mode; // Parallel select hi, lock, three-mode
  logic [7:0] cr_portable;
  logic [4:0] cr_floppy;
  logic [7:0] cr_uart;
  logic [7:0] cr_ir;
  logic [1:0] tape_drive_reg;
  logic [7:0] index;
  logic key_hi;
  logic strap_taken;
  scr_key_state_type key_state;
  scr_if_mode_type if_mode;
  logic config_register_lock;
  logic three_mode_enable;
  logic [15:0] key_port;
  logic [7:0] key_value;
  logic key_double;
  logic dat_wr;
  logic open;

  // Index decode used only by the read path
  function automatic logic is_known(input logic [7:0] idx);
    is_known = (idx >= `SCR_IDX_PROTECT) && (idx <= `SCR_IDX_IR);
  endfunction : is_known

  assign config_register_lock = cr_mode[1];
  assign three_mode_enable = cr_mode[0];
  assign open = (key_state == SCR_KEY_OPEN);
  // Key select: high bit is a strap, low bit lives in the UART register
  assign key_port = key_hi ? `SCR_KEY_PORT_HI : `SCR_KEY_PORT_LO; // R19
  assign key_double = key_hi; // R19
  always_comb begin
    case ({key_hi, cr_uart[`SCR_B_KEYLO]})
      2'b00: key_value = `SCR_KEY_00;
      2'b01: key_value = `SCR_KEY_01;
      2'b10: key_value = `SCR_KEY_10;
      default: key_value = `SCR_KEY_11;
    endcase
  end
  // Index port shares the key port address, data port sits one above
  assign dat_wr = i_io_wr && open && (i_io_addr == key_port + 16'h0001); // R5

  // Strap sampled once after reset release, never under the reset itself
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_taken <= 1'b0;
      key_hi <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      key_hi <= i_key_select_hi_strap;
    end
  end

  // ****************************************************************
  // Extended-function entry and index
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      key_state <= SCR_KEY_IDLE;
      index <= 8'h00;
    end else if (strap_taken && i_io_wr && (i_io_addr == key_port)) begin
      case (key_state)
        SCR_KEY_IDLE: begin
          if (i_io_wdata == key_value) begin
            key_state <= key_double ? SCR_KEY_HALF : SCR_KEY_OPEN; // R19
          end
        end
        SCR_KEY_HALF: begin
          key_state <= (i_io_wdata == key_value) ? SCR_KEY_OPEN : SCR_KEY_IDLE; // R19
        end
        SCR_KEY_OPEN: begin
          if (i_io_wdata == `SCR_EXIT_KEY) begin
            key_state <= SCR_KEY_IDLE;
          end else begin
            index <= i_io_wdata; // R5
          end
        end
        default: key_state <= SCR_KEY_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Lock is one-way: once set only a hardware reset clears it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cr_protect <= `SCR_RST_PROTECT;
      cr_mode <= `SCR_RST_MODE;
      cr_portable <= `SCR_RST_PORTABLE;
      cr_floppy <= `SCR_RST_FLOPPY;
      cr_uart <= `SCR_RST_UART;
      cr_ir <= `SCR_RST_IR;
    end else if (dat_wr && !config_register_lock) begin // R6 R25
      case (index)
        `SCR_IDX_PROTECT: cr_protect <= i_io_wdata; // R1 R4
        `SCR_IDX_MODE: cr_mode <= {i_io_wdata[7], i_io_wdata[`SCR_B_LOCK], i_io_wdata[`SCR_B_3MODE]}; // R9
        `SCR_IDX_PORTABLE: cr_portable <= i_io_wdata;
        `SCR_IDX_FLOPPY: cr_floppy <= i_io_wdata[4:0]; // R12
        `SCR_IDX_UART: cr_uart <= i_io_wdata;
        `SCR_IDX_IR: cr_ir <= i_io_wdata;
        default: cr_protect <= cr_protect;
      endcase
    end
  end

  // Tape drive register is only reachable with three-mode on
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tape_drive_reg <= 2'b00;
    end else if (i_io_wr && three_mode_enable && (i_io_addr == `SCR_TAPE_PORT)) begin // R7
      tape_drive_reg <= i_io_wdata[5:4];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [7:0] next_rdata;
  logic next_rvalid;
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = 1'b0;
    if (i_io_rd && open && (i_io_addr == key_port)) begin
      next_rvalid = 1'b1;
      next_rdata = index;
    end else if (i_io_rd && open && (i_io_addr == key_port + 16'h0001)) begin
      next_rvalid = 1'b1;
      if (!config_register_lock && is_known(index)) begin // R6 R25
        case (index)
          `SCR_IDX_PROTECT: next_rdata = cr_protect;
          `SCR_IDX_MODE: next_rdata = {cr_mode, 1'b0, CHIP_ID}; // R9
          `SCR_IDX_PORTABLE: next_rdata = cr_portable;
          `SCR_IDX_FLOPPY: next_rdata = {3'b000, cr_floppy}; // R12
          `SCR_IDX_UART: next_rdata = cr_uart;
          default: next_rdata = cr_ir;
        endcase
      end
    end else if (i_io_rd && three_mode_enable && (i_io_addr == `SCR_TAPE_PORT)) begin // R7
      next_rvalid = 1'b1;
      next_rdata = {2'b00, tape_drive_reg, 4'h0};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata <= 8'h00;
      o_io_rdata_valid <= 1'b0;
    end else begin
      o_io_rdata <= next_rdata;
      o_io_rdata_valid <= next_rvalid;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Value moves only when stages two and three agree, filtering one-cycle glitches
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_q;
  assign pin_raw = {i_drive_write_protect_in_n, i_dock_detect_in, i_infrared_receive1,
                    i_infrared_receive2, i_uart_b_serial_in};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
          pin_s3[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_q[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Floppy drive interface
  // ****************************************************************
  // Forcing happens at the logical level, then polarity applies to the pin
  logic fd_pol;
  logic wp_active;
  logic normal_rwc;
  logic next_rwc;
  assign fd_pol = cr_floppy[`SCR_B_FDPOL];
  assign wp_active = pin_q[4] ^ ~fd_pol; // R16
  assign normal_rwc = cr_floppy[`SCR_B_DRVTYPE] ? i_fdc_high_rate : ~i_fdc_high_rate; // R15
  always_comb begin
    next_rwc = normal_rwc;
    if (three_mode_enable) begin // R8
      case (tape_drive_reg)
        2'b01: next_rwc = 1'b0;
        2'b10: next_rwc = 1'b1;
        default: next_rwc = normal_rwc;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive_write_gate_n <= 1'b1;
      o_drive_write_data_n <= 1'b1;
      o_write_protected <= 1'b0;
      o_reduced_write_current_n <= 1'b1;
    end else begin
      o_drive_write_gate_n <= (cr_protect[`SCR_B_WR_DISABLE] | i_fdc_write_gate_n) ^ fd_pol; // R2 R16
      o_drive_write_data_n <= (cr_protect[`SCR_B_WR_DISABLE] | i_fdc_write_data_n) ^ fd_pol; // R2 R16
      o_write_protected <= cr_protect[`SCR_B_SW_PROTECT] | wp_active; // R3
      o_reduced_write_current_n <= next_rwc ^ fd_pol; // R16
    end
  end

  // Interface mode follows the bits at reset and while change is enabled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      if_mode <= SCR_IF_AT; // R13
    end else if (cr_floppy[`SCR_B_IFCHG]) begin // R13
      case (cr_floppy[`SCR_B_DRVTYPE:`SCR_B_RECSEL]) // R14
        2'b00: if_mode <= SCR_IF_COMPAT;
        2'b01: if_mode <= SCR_IF_SYSTEM2;
        default: if_mode <= SCR_IF_AT;
      endcase
    end
  end

  // ****************************************************************
  // Portable pins and plain configuration outputs
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_portable_floppy_enable_out <= 1'b0;
      o_portable_ext_enable_out <= 1'b0;
      o_docked <= 1'b0;
      o_host_if_mode <= 2'b00;
      o_second_drive_installed <= 1'b0;
      o_media_id <= 2'b00;
      o_boot_drive <= 2'b00;
      o_parallel_mode_select_hi <= 1'b0;
      o_three_mode_enable <= 1'b0;
      o_infrared_half_duplex <= 1'b0;
    end else begin
      o_portable_floppy_enable_out <= i_floppy_enable_req ^ ~cr_portable[7]; // R10
      o_portable_ext_enable_out <= (|(i_parallel_mode & cr_portable[3:0])) ^ ~cr_portable[6]; // R10 R11
      o_docked <= pin_q[3] ^ ~cr_portable[4]; // R10
      o_host_if_mode <= if_mode;
      o_second_drive_installed <= (if_mode == SCR_IF_SYSTEM2) && !cr_floppy[`SCR_B_DRV2]; // R17
      o_media_id <= cr_protect[3:2]; // R4
      o_boot_drive <= cr_protect[1:0]; // R4
      o_parallel_mode_select_hi <= cr_mode[2];
      o_three_mode_enable <= three_mode_enable; // R7
      o_infrared_half_duplex <= cr_ir[`SCR_B_INFRARED_HALF_DUPLEX]; // R23
    end
  end

  // ****************************************************************
  // UART clock enables
  // ****************************************************************
  // Both UARTs share one divide-by-13 prescaler to save a counter
  logic [3:0] div13;
  logic div13_hit;
  assign div13_hit = (div13 == 4'(`SCR_HOST_DIV13 - 1));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div13 <= 4'h0;
      o_uart_a_baud_tick <= 1'b0;
      o_uart_b_baud_tick <= 1'b0;
    end else begin
      div13 <= div13_hit ? 4'h0 : div13 + 4'h1;
      o_uart_a_baud_tick <= cr_uart[7] | div13_hit; // R18
      o_uart_b_baud_tick <= cr_uart[6] | div13_hit; // R18
    end
  end

  // ****************************************************************
  // UART B and infrared routing
  // ****************************************************************
  logic ir_on;
  logic tx_line;
  logic rx_pin;
  logic rx_line;
  assign ir_on = !cr_uart[`SCR_B_IRSEL] && cr_ir[2:1] != 2'b00; // R20 R24
  // ASK variants drive the emitter inverted
  assign tx_line = (i_uart_b_sout ^ cr_uart[0]) ^ cr_ir[2]; // R21 R24
  always_comb begin
    case (cr_ir[5:4]) // R22
      2'b01: rx_pin = pin_q[2];
      2'b10: rx_pin = pin_q[1];
      default: rx_pin = 1'b1;
    endcase
  end
  // Half duplex blinds the receiver while UART B sends a low bit
  assign rx_line = (cr_ir[`SCR_B_INFRARED_HALF_DUPLEX] && !i_uart_b_sout) ? 1'b1 : rx_pin; // R23

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_uart_b_sin <= 1'b1;
      o_uart_b_serial_out <= 1'b1;
      o_infrared_transmit1 <= 1'b0;
      o_infrared_transmit1_oe <= 1'b0;
      o_infrared_transmit2 <= 1'b0;
      o_infrared_transmit2_oe <= 1'b0;
    end else begin
      if (cr_uart[`SCR_B_IRSEL]) begin
        o_uart_b_sin <= pin_q[0] ^ cr_uart[1]; // R21
      end else begin
        o_uart_b_sin <= ir_on ? (rx_line ^ cr_uart[1]) : 1'b1; // R21 R24
      end
      o_uart_b_serial_out <= cr_uart[`SCR_B_IRSEL] ? (i_uart_b_sout ^ cr_uart[0]) : 1'b1; // R20
      o_infrared_transmit1 <= tx_line;
      o_infrared_transmit2 <= tx_line;
      o_infrared_transmit1_oe <= ir_on && (cr_ir[7:6] == 2'b01); // R22
      o_infrared_transmit2_oe <= ir_on && (cr_ir[7:6] == 2'b10); // R22
    end
  end

  // ****************************************************************
  // Automatic power-down
  // ****************************************************************
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic [7:0] apd_left;
  logic [7:0] apd_load;
  assign sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));
  always_comb begin
    case ({cr_protect[7], cr_protect[6]}) // R1
      2'b00: apd_load = `SCR_APD_T0_S;
      2'b01: apd_load = `SCR_APD_T1_S;
      2'b10: apd_load = `SCR_APD_T2_S;
      default: apd_load = `SCR_APD_T3_S;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sec_cnt <= 32'h0;
      apd_left <= `SCR_APD_T0_S;
      o_powerdown_request <= 1'b0;
    end else begin
      sec_cnt <= (sec_tick || i_floppy_activity) ? 32'h0 : sec_cnt + 32'h1;
      if (i_floppy_activity) begin
        apd_left <= apd_load; // R26
      end else if (sec_tick && apd_left != 8'h00) begin
        apd_left <= apd_left - 8'h01; // R1
      end
      o_powerdown_request <= (apd_left == 8'h00) && !i_floppy_activity; // R26
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_key_pair;
    (i_io_wr && i_io_addr == key_port && i_io_wdata == key_value && key_double && key_state == SCR_KEY_IDLE)
    ##1 (i_io_wr && i_io_addr == key_port && i_io_wdata == key_value);
  endsequence
  sequence s_locked_read;
    open && config_register_lock && i_io_rd && i_io_addr == key_port + 16'h0001;
  endsequence

  chk_key_double: assert property (@(posedge i_clk) disable iff (!i_rstn) // R19
    s_key_pair |=> open) else $error("double key write did not open");
  chk_lock_read: assert property (@(posedge i_clk) disable iff (!i_rstn) // R25
    s_locked_read |=> o_io_rdata_valid && o_io_rdata == 8'h00) else $error("locked read not zero");
  chk_lock_write: assert property (@(posedge i_clk) disable iff (!i_rstn) // R6
    config_register_lock |=> $stable(cr_ir) && $stable(cr_uart) && config_register_lock)
    else $error("locked register changed");
  chk_chip_id: assert property (@(posedge i_clk) disable iff (!i_rstn) // R9
    (i_io_rd && open && !config_register_lock && index == `SCR_IDX_MODE && i_io_addr == key_port + 16'h0001)
    |=> o_io_rdata[3:0] == CHIP_ID) else $error("chip id wrong");
  chk_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
    (next_rvalid && open && index == `SCR_IDX_FLOPPY && i_io_addr == key_port + 16'h0001)
    |-> next_rdata[7:5] == 3'b000) else $error("reserved bits not zero");
  chk_write_block: assert property (@(posedge i_clk) disable iff (!i_rstn) // R2
    (cr_protect[`SCR_B_WR_DISABLE] && !fd_pol) |=> o_drive_write_gate_n && o_drive_write_data_n)
    else $error("write not blocked");
  chk_sw_protect: assert property (@(posedge i_clk) disable iff (!i_rstn) // R3
    cr_protect[`SCR_B_SW_PROTECT] |=> o_write_protected) else $error("protect not forced");
  chk_baud_slow: assert property (@(posedge i_clk) disable iff (!i_rstn) // R18
    (o_uart_a_baud_tick && !cr_uart[7] && $stable(cr_uart)) |=> !o_uart_a_baud_tick[*8])
    else $error("slow baud tick too often");
  chk_ir_off: assert property (@(posedge i_clk) disable iff (!i_rstn) // R24
    (cr_ir[2:1] == 2'b00) |=> !o_infrared_transmit1_oe && !o_infrared_transmit2_oe)
    else $error("ir disabled but driving");
  chk_apd_reload: assert property (@(posedge i_clk) disable iff (!i_rstn) // R26
    i_floppy_activity |=> !o_powerdown_request ##1 !o_powerdown_request)
    else $error("power-down despite activity");
endmodule : scr_config_regs
`default_nettype wire

// *** logic/scr_pkg.sv ***
`default_nettype none
package scr_pkg;
  // Host interface mode chosen by drive type and recording select
  typedef enum logic [1:0] {SCR_IF_COMPAT, SCR_IF_SYSTEM2, SCR_IF_AT} scr_if_mode_type;
  // Unlock key sequencer
  typedef enum logic [1:0] {SCR_KEY_IDLE, SCR_KEY_HALF, SCR_KEY_OPEN} scr_key_state_type;
endpackage : scr_pkg
`default_nettype wire

// *** tb/scr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host I/O cycle model
// ****************************************************************
module scr_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_valid,
  output logic [15:0] o_addr = 16'h0000,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_wdata = 8'h00
);
  // One strobe cycle launched off the falling edge, bus scrambled after
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : io_wr
  // Answer stands one cycle only, so look at every falling edge
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    ok = 1'b0;
    d = 8'h00;
    repeat (3) begin
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      if (i_valid === 1'b1 && !ok) begin
        d = i_rdata;
        ok = 1'b1;
      end
    end
  endtask : io_rd
  // Single key, then index before data access
  task automatic open_cfg();
    io_wr(16'h0250, 8'h89);
  endtask : open_cfg
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    io_wr(16'h0250, i);
    io_wr(16'h0251, d);
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d, output logic ok);
    io_wr(16'h0250, i);
    io_rd(16'h0251, d, ok);
  endtask : cfg_rd
endmodule : scr_host_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [15:0] i_io_addr;
  logic i_io_wr, i_io_rd, o_io_rdata_valid, o_powerdown_request, o_drive_write_gate_n, o_write_protected;
  logic [7:0] i_io_wdata, o_io_rdata;
  logic i_floppy_activity = 1'b0;
  logic i_fdc_write_gate_n = 1'b0;
  logic i_fdc_write_data_n = 1'b1, i_fdc_high_rate = 1'b0, i_floppy_enable_req = 1'b0, i_dock_detect_in = 1'b0;
  logic i_uart_b_sout = 1'b1;
  logic [3:0] i_parallel_mode = 4'h0;
  logic o_drive_write_data_n, o_reduced_write_current_n, o_portable_floppy_enable_out;
  logic o_portable_ext_enable_out, o_docked, o_uart_b_serial_out;
  logic [1:0] o_media_id, o_boot_drive, o_host_if_mode;
  logic o_second_drive_installed;
  logic i_drive_write_protect_in_n = 1'b1;
  int error_cnt = 0;
  int cmp_count = 0;
  // ****************************************************************
  // Design and host
  // ****************************************************************
  scr_config_regs #(.SEC_CYCLES(10)) scr_config_regs_i (.i_clk, .i_rstn, .i_io_addr, .i_io_wr, .i_io_rd,
    .i_io_wdata, .o_io_rdata, .o_io_rdata_valid, .i_key_select_hi_strap(1'b0), .i_floppy_activity,
    .o_powerdown_request, .i_fdc_write_gate_n, .i_fdc_write_data_n, .o_drive_write_gate_n,
    .o_drive_write_data_n, .i_drive_write_protect_in_n, .o_write_protected, .o_media_id, .o_boot_drive,
    .i_fdc_high_rate, .o_reduced_write_current_n, .o_parallel_mode_select_hi(),
    .o_three_mode_enable(), .i_floppy_enable_req, .o_portable_floppy_enable_out,
    .i_parallel_mode, .o_portable_ext_enable_out, .i_dock_detect_in, .o_docked,
    .o_host_if_mode, .o_second_drive_installed, .o_uart_a_baud_tick(), .o_uart_b_baud_tick(),
    .i_uart_b_sout, .i_uart_b_serial_in(1'b1), .i_infrared_receive1(1'b1),
    .i_infrared_receive2(1'b1), .o_uart_b_sin(), .o_uart_b_serial_out, .o_infrared_transmit1(),
    .o_infrared_transmit1_oe(), .o_infrared_transmit2(), .o_infrared_transmit2_oe(),
    .o_infrared_half_duplex());
  scr_host_model scr_host_model_i (.i_clk, .i_rdata(o_io_rdata), .i_valid(o_io_rdata_valid),
    .o_addr(i_io_addr), .o_wr(i_io_wr), .o_rd(i_io_rd), .o_wdata(i_io_wdata));
  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp8
  // A missing answer is a hang, so it ends the run
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    scr_host_model_i.cfg_rd(idx, d, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    cmp8(d, e);
  endtask : rd_chk
  task automatic wr_settle(input logic [7:0] idx, input logic [7:0] d);
    scr_host_model_i.cfg_wr(idx, d);
    repeat (3) @(negedge i_clk);
  endtask : wr_settle
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    rd_chk(8'h09, 8'h05);
    rd_chk(8'h0a, 8'h1f);
    rd_chk(8'h0c, 8'h28);
    rd_chk(8'h0d, 8'ha3);
    rd_chk(8'h0b, 8'h0c);
  endtask : t_defaults
  task automatic t_floppy_if();
    wr_settle(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'h1f);
    cmp8({6'h0, o_host_if_mode}, 8'h02);
    wr_settle(8'h0b, 8'h14);
    cmp8({6'h0, o_host_if_mode}, 8'h01);
    cmp8({7'h0, o_second_drive_installed}, 8'h01);
    wr_settle(8'h0b, 8'h10);
    cmp8({6'h0, o_host_if_mode}, 8'h00);
    // Change-enable off: new drive bits must not move the mode
    wr_settle(8'h0b, 8'h0c);
    cmp8({6'h0, o_host_if_mode}, 8'h00);
  endtask : t_floppy_if
  task automatic t_protect();
    wr_settle(8'h08, 8'h3e);
    cmp8({7'h0, o_drive_write_gate_n}, 8'h01);
    cmp8({7'h0, o_write_protected}, 8'h01);
    cmp8({4'h0, o_media_id, o_boot_drive}, 8'h0e);
    wr_settle(8'h08, 8'h00);
    cmp8({7'h0, o_drive_write_gate_n}, 8'h00);
    cmp8({7'h0, o_write_protected}, 8'h00);
  endtask : t_protect
  // Reset-time polarities; dock pin needs its synchroniser delay first
  task automatic t_pins();
    i_fdc_write_data_n = 1'b0;
    i_floppy_enable_req = 1'b1;
    i_parallel_mode = 4'h8;
    i_dock_detect_in = 1'b1;
    i_uart_b_sout = 1'b0;
    repeat (6) @(negedge i_clk);
    cmp8({7'h0, o_drive_write_data_n}, 8'h00);
    cmp8({7'h0, o_reduced_write_current_n}, 8'h00);
    cmp8({7'h0, o_portable_floppy_enable_out}, 8'h00);
    cmp8({7'h0, o_portable_ext_enable_out}, 8'h00);
    cmp8({7'h0, o_docked}, 8'h01);
    cmp8({7'h0, o_uart_b_serial_out}, 8'h00);
  endtask : t_pins
  // Countdown of 4 ticks of 10 cycles restarts on activity
  task automatic t_powerdown();
    @(negedge i_clk);
    i_floppy_activity = 1'b1;
    @(negedge i_clk);
    i_floppy_activity = 1'b0;
    repeat (30) @(negedge i_clk);
    cmp8({7'h0, o_powerdown_request}, 8'h00);
    repeat (20) @(negedge i_clk);
    cmp8({7'h0, o_powerdown_request}, 8'h01);
  endtask : t_powerdown
  task automatic t_lock();
    wr_settle(8'h09, 8'h40);
    wr_settle(8'h0d, 8'h00);
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'h09, 8'h00);
  endtask : t_lock
  // ****************************************************************
  // Clock, reset and sequence
  // ****************************************************************
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    repeat (6) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_clk);
    scr_host_model_i.open_cfg();
    t_defaults();
    t_floppy_if();
    t_protect();
    t_pins();
    t_powerdown();
    t_lock();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
